// ---- verilog/pmrg_pkg.sv ----
// Package: constants and types for the program memory read / EEPROM guard
package pmrg_pkg;
  localparam int CLK_MHZ        = 200;
  localparam int PERIOD_PS      = 5000;
  localparam int PROG_MIN_US    = 100;
  localparam int PROG_T0_US     = 1250;
  localparam int PROG_T1_US     = 2500;
  localparam int PROG_T2_US     = 5000;
  localparam int PROG_T3_US     = 10000;
  localparam int POWERUP_US     = 18000;
  localparam int PROG_MIN_CYC   = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_T0_CYC    = PROG_T0_US * CLK_MHZ;
  localparam int PROG_T1_CYC    = PROG_T1_US * CLK_MHZ;
  localparam int PROG_T2_CYC    = PROG_T2_US * CLK_MHZ;
  localparam int PROG_T3_CYC    = PROG_T3_US * CLK_MHZ;
  localparam int POWERUP_CYC    = POWERUP_US * CLK_MHZ;
  localparam int CNT_W          = 22;
  localparam int ADDR_HI_W      = 3;
  localparam int PADDR_W        = 11;
  localparam int EE_ADDR_W      = 7;
  localparam int EE_DEPTH       = 128;
  localparam int FLASH_DEPTH    = 2048;
  localparam logic [2:0] STEAL_SLOT = 3'h2;

  typedef enum logic [2:0] {
    PMRG_IDLE  = 3'b000,
    PMRG_WAIT  = 3'b001,
    PMRG_FETCH = 3'b010,
    PMRG_LATCH = 3'b011,
    PMRG_PROG  = 3'b100
  } pmrg_state_t;

  // Maximum programming time in cycles for the two-bit selector
  function automatic logic [CNT_W-1:0] pmrg_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    pmrg_limit = CNT_W'(PROG_T0_CYC);
      2'h1:    pmrg_limit = CNT_W'(PROG_T1_CYC);
      2'h2:    pmrg_limit = CNT_W'(PROG_T2_CYC);
      default: pmrg_limit = CNT_W'(PROG_T3_CYC);
    endcase
  endfunction : pmrg_limit
endpackage : pmrg_pkg

// ---- verilog/pmrg_flash_rom.sv ----
// Read-only program memory array, one synchronous read port
module pmrg_flash_rom
  import pmrg_pkg::*;
(
  input  wire logic               clk_sys,   // System clock
  input  wire logic               rdEn,      // Read strobe
  input  wire logic [PADDR_W-1:0] rdAddr,    // Word address
  output logic      [15:0]        rdData     // Registered word
);
  // No write port exists: program memory cannot be altered from here
  logic [15:0] romArray [FLASH_DEPTH];

  initial begin
    for (int i = 0; i < FLASH_DEPTH; i++) begin
      romArray[i] = 16'(i) ^ 16'ha5c3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rdEn) begin
      rdData <= romArray[rdAddr];
    end
  end
endmodule : pmrg_flash_rom

// ---- verilog/pmrg_ee_cell.sv ----
// Data EEPROM array with self-verifying programming model
module pmrg_ee_cell
  import pmrg_pkg::*;
(
  input  wire logic                 clk_sys,   // System clock
  input  wire logic                 reset,     // Synchronous reset
  input  wire logic                 progGo,    // Start programming pulse
  input  wire logic                 progAbort, // Timeout, stop programming
  input  wire logic [EE_ADDR_W-1:0] addr,      // Byte address
  input  wire logic [7:0]           wrData,    // Byte to program
  input  wire logic [7:0]           settle,    // Data-dependent time hint
  output logic      [7:0]           rdData,    // Array read, combinational
  output logic                      verifyOk   // Cell verified, one pulse
);
  logic [7:0]       cellArray [EE_DEPTH];
  logic [CNT_W-1:0] busyCnt_r;
  logic             busy_r;
  logic [CNT_W-1:0] need;

  // Cell time grows with the data; always at least the minimum
  assign need   = CNT_W'(PROG_MIN_CYC) + {settle, 12'h000};
  assign rdData = cellArray[addr];

  always_ff @(posedge clk_sys) begin
    verifyOk <= 1'b0;
    if (reset) begin
      busy_r    <= 1'b0;
      busyCnt_r <= '0;
    end else if (progGo) begin
      busy_r    <= 1'b1;
      busyCnt_r <= '0;
    end else if (busy_r && progAbort) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      busyCnt_r <= busyCnt_r + 1'b1;
      if (busyCnt_r + 1'b1 >= need) begin
        cellArray[addr] <= wrData;
        verifyOk        <= 1'b1;
        busy_r          <= 1'b0;
      end
    end
  end
endmodule : pmrg_ee_cell

// ---- verilog/pmrg_nvm_ctrl.sv ----
// Program memory read and data EEPROM write controller
module pmrg_nvm_ctrl
  import pmrg_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
  input  wire logic                 clk_sys,        // System clock
  input  wire logic                 reset,          // Sync reset, high
  input  wire logic                 powerOn,        // Reset is power-on
  input  wire logic                 instrTick,      // Instruction cycle end
  input  wire logic                 addrLowWe,      // Write low address
  input  wire logic                 addrHighWe,     // Write high address
  input  wire logic                 dataLowWe,      // Write low data
  input  wire logic [7:0]           wrByte,         // Software write data
  input  wire logic                 spaceSelWe,     // Write space select
  input  wire logic                 spaceSelIn,     // Space select value
  input  wire logic                 timeSelWe,      // Write time selector
  input  wire logic [1:0]           timeSelIn,      // Time selector value
  input  wire logic                 enableWe,       // Write program enable
  input  wire logic                 enableIn,       // Program enable value
  input  wire logic                 errClr,         // Clear error flag
  input  wire logic                 readSet,        // Set read start
  input  wire logic                 writeSet,       // Set write start
  input  wire logic                 unlockDone,     // Unlock sequence seen
  input  wire logic                 doneClr,        // Clear done flag
  output logic [7:0]                nvmAddrLow,     // Low address register
  output logic [7:0]                nvmAddrHigh,    // High address register
  output logic [7:0]                nvmDataLow,     // Low data register
  output logic [7:0]                nvmDataHigh,    // High data register
  output logic                      spaceSelect,    // 1 = program memory
  output logic [1:0]                maxProgTimeSel, // Max time selector
  output logic                      programEnable,  // Program enable bit
  output logic                      programErrFlag, // Write error flag
  output logic                      writeStart,     // Write start bit
  output logic                      readStart,      // Read start bit
  output logic                      programDoneFlag,// Write done flag
  output logic                      cpuHalt,        // Halt CPU execution
  output logic                      cycleSteal      // Suppress instruction
);
  pmrg_state_t      state_r;
  logic [2:0]       tickCnt_r;
  logic [CNT_W-1:0] progCnt_r;
  logic [CNT_W-1:0] porCnt_r;
  logic             porBusy_r;
  logic             romRd;
  logic [15:0]      romWord;
  logic [7:0]       eeWord;
  logic             verifyOk;
  logic             progGo;
  logic             timeout;
  logic             writeIgnore;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  pmrg_flash_rom uRom (
    .clk_sys (clk_sys),
    .rdEn    (romRd),
    .rdAddr  ({nvmAddrHigh[ADDR_HI_W-1:0], nvmAddrLow}),
    .rdData  (romWord)
  );

  pmrg_ee_cell uEe (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .progGo    (progGo),
    .progAbort (timeout),
    .addr      (nvmAddrLow[EE_ADDR_W-1:0]),
    .wrData    (nvmDataLow),
    .settle    (nvmDataLow),
    .rdData    (eeWord),
    .verifyOk  (verifyOk)
  );

  // Write with program space chosen is dropped
  assign writeIgnore = writeSet && spaceSelect;
  // Unlock, enable and no power-on delay all needed
  assign progGo = writeSet && !spaceSelect && unlockDone &&
                  programEnable && !porBusy_r && state_r == PMRG_IDLE;
  assign timeout = state_r == PMRG_PROG && !verifyOk &&
                   progCnt_r + 1'b1 >= pmrg_limit(maxProgTimeSel);
  assign romRd = state_r == PMRG_FETCH;
  assign cpuHalt    = state_r == PMRG_PROG;
  assign cycleSteal = state_r == PMRG_FETCH;

  // Power-on delay: counts from every reset that is power-on
  // Block writes until delay ends
  always_ff @(posedge clk_sys) begin
    if (reset && powerOn) begin
      porBusy_r <= 1'b1;
      porCnt_r  <= '0;
    end else if (!reset && porBusy_r) begin
      porCnt_r <= porCnt_r + 1'b1;
      if (porCnt_r + 1'b1 >= CNT_W'(POWERUP_CYCLES)) begin
        porBusy_r <= 1'b0;
      end
    end
  end

  // Only three high address bits stored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nvmAddrLow  <= 8'h00;
      nvmAddrHigh <= 8'h00;
    end else begin
      if (addrLowWe && !cpuHalt) nvmAddrLow <= wrByte;
      if (addrHighWe && !cpuHalt) begin
        nvmAddrHigh <= {5'h00, wrByte[ADDR_HI_W-1:0]};
      end
    end
  end

  // Control bits; enable survives non-power-on resets
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      spaceSelect    <= 1'b0;
      maxProgTimeSel <= 2'h0;
    end else if (!cpuHalt) begin
      if (spaceSelWe) spaceSelect <= spaceSelIn;
      if (timeSelWe) maxProgTimeSel <= timeSelIn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset && powerOn) begin
      programEnable <= 1'b0;
    end else if (!reset && enableWe) begin
      programEnable <= enableIn;
    end
  end

  // Error on timeout or non-power-on reset mid-write; set beats clear
  always_ff @(posedge clk_sys) begin
    if (reset && powerOn) begin
      programErrFlag <= 1'b0;
    end else if (reset) begin
      if (state_r == PMRG_PROG) programErrFlag <= 1'b1;
    end else if (timeout) begin
      programErrFlag <= 1'b1;
    end else if (progGo || errClr) begin
      programErrFlag <= 1'b0;
    end
  end

  // Done flag set on finish; set wins over clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      programDoneFlag <= 1'b0;
    end else if (state_r == PMRG_PROG && (verifyOk || timeout)) begin
      programDoneFlag <= 1'b1;
    end else if (doneClr) begin
      programDoneFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || progGo) begin
      progCnt_r <= '0;
    end else if (state_r == PMRG_PROG) begin
      progCnt_r <= progCnt_r + 1'b1;
    end
  end

  // Sequencer; read start is ignored while programming
  // Programming state never yields to a read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r    <= PMRG_IDLE;
      tickCnt_r  <= 3'h0;
      readStart  <= 1'b0;
      writeStart <= 1'b0;
    end else begin
      case (state_r)
        PMRG_IDLE: begin
          if (progGo) begin
            writeStart <= 1'b1;
            state_r    <= PMRG_PROG;
          end else if (readSet) begin
            readStart <= 1'b1;
            tickCnt_r <= 3'h0;
            state_r   <= PMRG_WAIT;
          end
        end
        PMRG_WAIT: begin
          if (instrTick) begin
            tickCnt_r <= tickCnt_r + 3'h1;
            if (tickCnt_r + 3'h1 == STEAL_SLOT - 3'h1) begin
              state_r <= PMRG_FETCH;
            end
          end
        end
        PMRG_FETCH: begin
          state_r <= PMRG_LATCH;
        end
        PMRG_LATCH: begin
          readStart <= 1'b0;
          state_r   <= PMRG_IDLE;
        end
        PMRG_PROG: begin
          if (verifyOk || timeout) begin
            writeStart <= 1'b0;
            state_r    <= PMRG_IDLE;
          end
        end
        default: state_r <= PMRG_IDLE;
      endcase
    end
  end

  // Latch the word one clock after the access
  // Held until next access or software write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nvmDataLow  <= 8'h00;
      nvmDataHigh <= 8'h00;
    end else if (state_r == PMRG_LATCH) begin
      if (spaceSelect) begin
        nvmDataLow  <= romWord[7:0];
        nvmDataHigh <= romWord[15:8];
      end else begin
        nvmDataLow  <= eeWord;
        nvmDataHigh <= 8'h00;
      end
    end else if (dataLowWe && !cpuHalt) begin
      nvmDataLow <= wrByte;
    end
  end

  sequence progRun_s;
    state_r == PMRG_PROG;
  endsequence

  guard_write_a: assert property (
    (writeIgnore && state_r == PMRG_IDLE) |=> !writeStart && !cpuHalt)
    else $error("write with program space started");

  latch_delay_a: assert property (
    (state_r == PMRG_FETCH) |=> ##1 (!readStart && state_r == PMRG_IDLE))
    else $error("read word not latched on time");

  data_hold_a: assert property (
    (state_r != PMRG_LATCH && !dataLowWe) |=> $stable(nvmDataHigh))
    else $error("data high changed without access");

  halt_prog_a: assert property (
    cpuHalt == writeStart)
    else $error("halt not tied to programming");

  por_block_a: assert property (
    porBusy_r |-> !writeStart && !cpuHalt)
    else $error("write started in power-on delay");

  start_guard_a: assert property (
    $rose(writeStart) |-> $past(programEnable) && $past(unlockDone))
    else $error("write started without enable");

  err_timeout_a: assert property (
    timeout |=> programErrFlag)
    else $error("timeout did not set error");

  done_end_a: assert property (
    (progRun_s ##0 (verifyOk || timeout)) |=> programDoneFlag && !writeStart)
    else $error("completion not flagged");

  addr_high_a: assert property (
    nvmAddrHigh[7:ADDR_HI_W] == 5'h00)
    else $error("high address upper bits set");

  steal_slot_a: assert property (
    (state_r == PMRG_IDLE && readSet && !progGo) |=> !cycleSteal)
    else $error("steal too early");

  steal_tick_a: assert property (
    $rose(cycleSteal) |-> $past(instrTick))
    else $error("steal without instruction end");

  steal_once_a: assert property (
    cycleSteal |=> !cycleSteal)
    else $error("steal longer than one cycle");
endmodule : pmrg_nvm_ctrl

// ---- verif/pmrg_testbench.sv ----
// Self-checking bench for the program read and EEPROM write guard
module testbench import pmrg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // Short power-on delay keeps the run brief
  localparam int PWRUP = 50;
  logic       clk_sys, reset, powerOn, instrTick, unlockDone;
  logic       addrLowWe, addrHighWe, dataLowWe, spaceSelWe, spaceSelIn;
  logic       timeSelWe, enableWe, enableIn, errClr, readSet, writeSet;
  logic       doneClr;
  logic [1:0] timeSelIn, maxProgTimeSel;
  logic [7:0] wrByte, nvmAddrLow, nvmAddrHigh, nvmDataLow, nvmDataHigh;
  logic       spaceSelect, programEnable, programErrFlag, writeStart;
  logic       readStart, programDoneFlag, cpuHalt, cycleSteal;
  int         badCount, testsRun;

  pmrg_nvm_ctrl #(.POWERUP_CYCLES(PWRUP)) uut (
    .clk_sys, .reset, .powerOn, .instrTick, .addrLowWe, .addrHighWe,
    .dataLowWe, .wrByte, .spaceSelWe, .spaceSelIn, .timeSelWe, .timeSelIn,
    .enableWe, .enableIn, .errClr, .readSet, .writeSet, .unlockDone,
    .doneClr, .nvmAddrLow, .nvmAddrHigh, .nvmDataLow, .nvmDataHigh,
    .spaceSelect, .maxProgTimeSel, .programEnable, .programErrFlag,
    .writeStart, .readStart, .programDoneFlag, .cpuHalt, .cycleSteal
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Random instruction cycle ends, as a CPU of mixed timing would give
  always @(posedge clk_sys) begin
    instrTick <= ($urandom_range(2) == 0);
  end

  // Image the program array is loaded with: address xor a fixed pattern
  function automatic logic [15:0] flashWord(input logic [PADDR_W-1:0] a);
    return 16'(a) ^ 16'ha5c3;
  endfunction : flashWord

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chkBit(input string nm, input logic e, input logic g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chkBit

  task automatic chkByte(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chkByte

  // One-cycle software strobe; an idle edge follows so strobes never merge
  task automatic poke(input int k, input logic [7:0] v);
    @(posedge clk_sys);
    wrByte <= v;
    spaceSelIn <= v[0];
    enableIn <= v[0];
    timeSelIn <= v[1:0];
    case (k)
      0: addrLowWe <= 1'b1;
      1: addrHighWe <= 1'b1;
      2: dataLowWe <= 1'b1;
      3: spaceSelWe <= 1'b1;
      4: timeSelWe <= 1'b1;
      5: enableWe <= 1'b1;
      6: readSet <= 1'b1;
      7: writeSet <= 1'b1;
      8: doneClr <= 1'b1;
      default: errClr <= 1'b1;
    endcase
    @(posedge clk_sys);
    {addrLowWe, addrHighWe, dataLowWe, spaceSelWe, timeSelWe} <= '0;
    {enableWe, readSet, writeSet, doneClr, errClr} <= '0;
    #1;
  endtask : poke

  // A wait that runs out counts a mismatch and lets the run go on
  task automatic waitFor(input int k, input logic lvl, input int lim,
                         output int n);
    logic cur;
    n = 0;
    cur = (k == 0) ? readStart : (k == 1) ? writeStart : cycleSteal;
    while (cur !== lvl) begin
      if (n >= lim) begin
        badCount++;
        $display("unexpected wait %0d: expected %b seen %b", k, lvl, cur);
        break;
      end
      @(posedge clk_sys);
      #1;
      n++;
      cur = (k == 0) ? readStart : (k == 1) ? writeStart : cycleSteal;
    end
  endtask : waitFor

  task automatic doReset(input logic po);
    @(posedge clk_sys);
    reset <= 1'b1;
    powerOn <= po;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    powerOn <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : doReset

  task automatic doRead(output logic [15:0] w);
    int n;
    poke(6, 8'h00);
    chkBit("readStart", 1'b1, readStart);
    waitFor(2, 1'b1, 400, n);
    @(posedge clk_sys);
    #1;
    chkBit("cycleSteal width", 1'b0, cycleSteal);
    chkBit("readStart latch", 1'b1, readStart);
    @(posedge clk_sys);
    #1;
    chkBit("readStart end", 1'b0, readStart);
    w = {nvmDataHigh, nvmDataLow};
  endtask : doRead

  initial begin
    logic [15:0] w0, w1, we;
    logic [7:0]  ha, la, d;
    int          n;
    // Reset from time zero keeps unknown state out of the checkers
    {reset, powerOn} = 2'h3;
    {unlockDone, addrLowWe, addrHighWe, dataLowWe} = '0;
    {spaceSelWe, spaceSelIn, timeSelWe, enableWe, enableIn, errClr} = '0;
    {readSet, writeSet, doneClr, timeSelIn, wrByte} = '0;
    badCount = 0;
    testsRun = 0;
    void'($urandom(46684));
    doReset(1'b1);
    chkBit("programEnable", 1'b0, programEnable);
    chkByte("nvmAddrHigh", 8'h00, nvmAddrHigh);
    // Fully armed write inside the power-on delay
    poke(5, 8'h01);
    @(posedge clk_sys);
    unlockDone <= 1'b1;
    poke(7, 8'h00);
    chkBit("writeStart in delay", 1'b0, writeStart);
    chkBit("cpuHalt in delay", 1'b0, cpuHalt);
    repeat (PWRUP) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      ha = (i == 0) ? 8'hff : 8'($urandom);
      la = (i == 0) ? 8'hff : 8'($urandom);
      poke(1, ha);
      chkByte("nvmAddrHigh", {5'h00, ha[2:0]}, nvmAddrHigh);
      poke(0, la);
      poke(3, 8'h01);
      doRead(w0);
      we = flashWord({ha[ADDR_HI_W-1:0], la});
      chkByte("flash low", we[7:0], w0[7:0]);
      chkByte("flash high", we[15:8], w0[15:8]);
      repeat ($urandom_range(8, 1)) @(posedge clk_sys);
      #1;
      chkByte("held low", w0[7:0], nvmDataLow);
      chkByte("held high", w0[15:8], nvmDataHigh);
      poke(7, 8'h00);
      chkBit("writeStart flash", 1'b0, writeStart);
      chkBit("cpuHalt flash", 1'b0, cpuHalt);
      doRead(w1);
      chkByte("reread low", we[7:0], w1[7:0]);
      chkByte("reread high", we[15:8], w1[15:8]);
    end
    poke(3, 8'h00);
    poke(5, 8'h00);
    poke(7, 8'h00);
    chkBit("writeStart disabled", 1'b0, writeStart);
    poke(5, 8'h01);
    @(posedge clk_sys);
    unlockDone <= 1'b0;
    poke(7, 8'h00);
    chkBit("writeStart no unlock", 1'b0, writeStart);
    @(posedge clk_sys);
    unlockDone <= 1'b1;
    la = 8'($urandom_range(127));
    d = 8'($urandom_range(3));
    ha = 8'($urandom_range(3));
    poke(0, la);
    poke(2, d);
    poke(4, ha);
    chkByte("maxProgTimeSel", ha, {6'h00, maxProgTimeSel});
    poke(7, 8'h00);
    chkBit("writeStart", 1'b1, writeStart);
    chkBit("cpuHalt", 1'b1, cpuHalt);
    poke(6, 8'h00);
    chkBit("read while busy", 1'b0, readStart);
    waitFor(1, 1'b0, 40000, n);
    // Verify comes long before the shortest time limit
    chkBit("write length", 1'b1, n + 8 >= PROG_MIN_CYC);
    chkBit("verify end", 1'b1, n <= PROG_MIN_CYC + d * 4096);
    chkBit("programDoneFlag", 1'b1, programDoneFlag);
    chkBit("programErrFlag", 1'b0, programErrFlag);
    chkBit("cpuHalt end", 1'b0, cpuHalt);
    poke(8, 8'h00);
    chkBit("done cleared", 1'b0, programDoneFlag);
    doRead(w0);
    chkByte("readback low", d, w0[7:0]);
    chkByte("readback high", 8'h00, w0[15:8]);
    poke(7, 8'h00);
    repeat (300) @(posedge clk_sys);
    doReset(1'b0);
    chkBit("err after reset", 1'b1, programErrFlag);
    chkBit("enable kept", 1'b1, programEnable);
    chkBit("writeStart reset", 1'b0, writeStart);
    poke(9, 8'h00);
    chkBit("err cleared", 1'b0, programErrFlag);
    doReset(1'b1);
    chkBit("enable power-on", 1'b0, programEnable);
    print_verdict();
  end
endmodule : testbench
